// ==== hdl/mss_consts.vh ====
// Purpose: Shared constants for the motor start sequencer.
// Assumes: 20 MHz clock, byte addressed AXI4-Lite register window.
// Notes: Register offsets are aligned 32-bit words.
// Function
// RULE1: After power-up, initialise peripherals and load parameters before driving.
// RULE2: With zero speed command, idle in sleep or standby by mode and wake pin.
// RULE3: Nonzero speed command leaves idle for the detection-enable check.
// RULE4: Direction change: mode 0 to detection check, mode 1 to handoff compare.
// RULE5: Detection enabled goes to standstill check, disabled goes to brake decision.
// RULE6: Back-EMF below either threshold means stationary, go to brake decision.
// RULE7: Spinning forward goes to rejoin decision, reverse to reverse-drive decision.
// RULE8: Rejoin enabled compares speed to rejoin threshold, disabled goes to coast.
// RULE9: Above rejoin threshold seed closed loop, else enter open loop.
// RULE10: Reverse with reverse drive enabled checks speed, disabled goes to coast.
// RULE11: Reverse decelerates closed loop above handoff, open loop below it.
// RULE12: Open-loop reverse crosses zero, accelerates forward, then closes the loop.
// RULE13: Coast enabled runs coast routine, disabled goes to brake decision.
// RULE14: Coast turns off all six bridge transistors for coast duration.
// RULE15: After coast, go to brake decision and treat motor as stationary.
// RULE16: Brake enabled runs brake routine, disabled goes to stationary start-up.
// RULE17: Brake type picks timed brake or current brake with persistence.
// RULE18: Current brake ends at brake time even if current stays high.
// RULE19: Timed brake uses chosen side, current brake uses low side only.
// RULE20: After stationary start-up method, enter open-loop acceleration.
// RULE21: Closed loop commutates by sensorless field oriented control.
// RULE22: Spin detection derives speed, position, direction from phase voltages.
`ifndef MSS_CONSTS_VH
`define MSS_CONSTS_VH
`define MSS_OFF_CTRL 8'h00
`define MSS_OFF_THR0 8'h04
`define MSS_OFF_THR1 8'h08
`define MSS_OFF_TIME 8'h0C
`define MSS_OFF_STAT 8'h10
`define MSS_OFF_ISD 8'h14
`define MSS_CTRL_RST 32'h0000_0000
`define MSS_THR0_RST 32'h0010_0010
`define MSS_THR1_RST 32'h0020_0040
`define MSS_TIME_RST 32'h0000_0000
`define MSS_B_IDLE 0
`define MSS_B_SPIN 1
`define MSS_B_DIRMODE 2
`define MSS_B_REJOIN 3
`define MSS_B_REVDRV 4
`define MSS_B_COAST 5
`define MSS_B_BRAKE 6
`define MSS_B_BRKTYPE 7
`define MSS_B_BRKSIDE 8
`define MSS_B_DIRCMD 9
`define MSS_B_DIRGO 10
`define MSS_TICK_US 1
`define MSS_CLK_MHZ 20
`define MSS_TICK_CYC (`MSS_TICK_US * `MSS_CLK_MHZ)
`define MSS_TICK_MS_US 1000
`define MSS_INIT_US 10
`define MSS_INIT_CYC (`MSS_INIT_US * `MSS_CLK_MHZ)
`define MSS_RESP_OKAY 2'b00
`define MSS_RESP_DECERR 2'b11
`endif

// ==== hdl/mss_start_sequencer.v ====
// Purpose: Start decision state machine of a sensorless motor controller.
// Assumes: All inputs synchronous to mclk; measurements come from outside.
// Notes: Durations are counted in milliseconds from a 1 us enable tick.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "mss_consts.vh"
module mss_start_sequencer #(
  parameter MS_US = `MSS_TICK_MS_US,
  parameter INIT_CYC = `MSS_INIT_CYC
) (
  input wire mclk,
  input wire nrst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [15:0] speed_command,
  input wire speed_wake_pin,
  input wire params_loaded,
  input wire [15:0] phase_emf,
  input wire [15:0] phase_speed,
  input wire [15:0] phase_angle,
  input wire spin_reverse,
  input wire spin_valid,
  input wire [15:0] phase_current,
  input wire startup_done,
  output reg init_request,
  output reg sleep_mode,
  output reg standby_mode,
  output reg spin_detect_start,
  output reg [2:0] hs_on,
  output reg [2:0] ls_on,
  output reg bridge_drive,
  output reg startup_run,
  output reg open_loop_run,
  output reg closed_loop_run,
  output reg reverse_run,
  output reg seed_valid,
  output reg [15:0] seed_speed,
  output reg [15:0] seed_angle
);

  localparam [14:0] S_INIT = 15'h0001;
  localparam [14:0] S_IDLE = 15'h0002;
  localparam [14:0] S_ISDCHK = 15'h0004;
  localparam [14:0] S_ISD = 15'h0008;
  localparam [14:0] S_DIRCHK = 15'h0010;
  localparam [14:0] S_REJOIN = 15'h0020;
  localparam [14:0] S_REVCHK = 15'h0040;
  localparam [14:0] S_COASTCHK = 15'h0080;
  localparam [14:0] S_COAST = 15'h0100;
  localparam [14:0] S_BRKCHK = 15'h0200;
  localparam [14:0] S_BRAKE = 15'h0400;
  localparam [14:0] S_START = 15'h0800;
  localparam [14:0] S_OPEN = 15'h1000;
  localparam [14:0] S_CLOSED = 15'h2000;
  localparam [14:0] S_REVCL = 15'h4000;

  reg [14:0] state_q;
  reg [14:0] state_d;
  reg [31:0] ctrl_q;
  reg [31:0] thr0_q;
  reg [31:0] thr1_q;
  reg [31:0] time_q;
  reg [15:0] isd_speed_q;
  reg [15:0] isd_angle_q;
  reg isd_rev_q;
  reg rev_open_q;
  reg [15:0] tick_q;
  reg [15:0] ms_q;
  reg [15:0] dur_q;
  reg [15:0] pers_q;
  reg [15:0] init_q;
  reg dir_seen_q;
  reg aw_hold_q;
  reg w_hold_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  wire tick_1us = (tick_q == `MSS_TICK_CYC - 1);
  wire tick_1ms = tick_1us && (ms_q == MS_US[15:0] - 16'h0001);
  wire state_new = (state_q != state_d);
  wire dir_req = ctrl_q[`MSS_B_DIRGO] & ~dir_seen_q;
  wire [15:0] standstill_threshold = thr0_q[15:0];
  wire [15:0] tach_emf_threshold = thr0_q[31:16];
  wire [15:0] forward_rejoin_threshold = thr1_q[15:0];
  wire [15:0] loop_handoff_threshold = thr1_q[31:16];
  wire [7:0] coast_duration = time_q[7:0];
  wire [7:0] braking_duration = time_q[15:8];
  wire [7:0] braking_persistence = time_q[23:16];
  wire [7:0] braking_current_threshold = time_q[31:24];
  wire [15:0] rd_stat = {isd_rev_q, rev_open_q, state_q[13:0]};

  // Byte lane merge used by every writable register.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // Idle selection reads mode bit and wake pin; shared by idle outputs.
  function use_sleep;
    input mode;
    input wake;
    begin
      use_sleep = mode & ~wake;
    end
  endfunction

  // Decision chain. Judgement steps pass in one cycle each so the trace
  // through the flow stays visible on the status register.
  always @* begin
    state_d = state_q;
    case (state_q)
      S_INIT: begin
        if (params_loaded && init_q == 16'h0000)
          state_d = S_IDLE; // RULE1
      end
      S_IDLE: begin
        if (speed_command != 16'h0000)
          state_d = S_ISDCHK; // RULE3
      end
      S_ISDCHK: begin
        if (ctrl_q[`MSS_B_SPIN])
          state_d = S_ISD; // RULE5
        else
          state_d = S_BRKCHK; // RULE5
      end
      S_ISD: begin
        if (spin_valid) begin
          if (phase_emf < standstill_threshold ||
              phase_emf < tach_emf_threshold)
            state_d = S_BRKCHK; // RULE6
          else
            state_d = S_DIRCHK; // RULE6
        end
      end
      S_DIRCHK: begin
        if (isd_rev_q)
          state_d = S_REVCHK; // RULE7
        else
          state_d = S_REJOIN; // RULE7
      end
      S_REJOIN: begin
        if (!ctrl_q[`MSS_B_REJOIN])
          state_d = S_COASTCHK; // RULE8
        else if (isd_speed_q > forward_rejoin_threshold)
          state_d = S_CLOSED; // RULE9
        else
          state_d = S_OPEN; // RULE9
      end
      S_REVCHK: begin
        if (ctrl_q[`MSS_B_REVDRV])
          state_d = S_REVCL; // RULE10
        else
          state_d = S_COASTCHK; // RULE10
      end
      S_REVCL: begin
        if (phase_speed < loop_handoff_threshold)
          state_d = S_OPEN; // RULE11
      end
      S_COASTCHK: begin
        if (ctrl_q[`MSS_B_COAST])
          state_d = S_COAST; // RULE13
        else
          state_d = S_BRKCHK; // RULE13
      end
      S_COAST: begin
        if (dur_q >= {8'h00, coast_duration})
          state_d = S_BRKCHK; // RULE15
      end
      S_BRKCHK: begin
        if (ctrl_q[`MSS_B_BRAKE])
          state_d = S_BRAKE; // RULE16
        else
          state_d = S_START; // RULE16
      end
      S_BRAKE: begin
        if (dur_q >= {8'h00, braking_duration})
          state_d = S_START; // RULE17 RULE18
        else if (ctrl_q[`MSS_B_BRKTYPE] &&
                 pers_q >= {8'h00, braking_persistence})
          state_d = S_START; // RULE17
      end
      S_START: begin
        if (startup_done)
          state_d = S_OPEN; // RULE20
      end
      S_OPEN: begin
        if (phase_speed > loop_handoff_threshold && !rev_open_q)
          state_d = S_CLOSED; // RULE12
        else if (isd_rev_q && rev_open_q && phase_speed == 16'h0000)
          state_d = S_OPEN; // RULE12
      end
      S_CLOSED: begin
        state_d = S_CLOSED; // RULE21
      end
      default: state_d = S_INIT;
    endcase
    if (speed_command == 16'h0000 && state_q != S_INIT)
      state_d = S_IDLE; // RULE2
    else if (dir_req && state_q != S_INIT && state_q != S_IDLE) begin
      if (ctrl_q[`MSS_B_DIRMODE])
        state_d = S_REVCL; // RULE4
      else
        state_d = S_ISDCHK; // RULE4
    end
  end

  // Sequencer state, timers and spin detection capture.
  always @(posedge mclk) begin
    if (!nrst) begin
      state_q <= S_INIT;
      tick_q <= 16'h0000;
      ms_q <= 16'h0000;
      dur_q <= 16'h0000;
      pers_q <= 16'h0000;
      init_q <= INIT_CYC[15:0];
      isd_speed_q <= 16'h0000;
      isd_angle_q <= 16'h0000;
      isd_rev_q <= 1'b0;
      rev_open_q <= 1'b0;
      dir_seen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tick_q <= tick_1us ? 16'h0000 : tick_q + 16'h0001;
      if (tick_1us)
        ms_q <= tick_1ms ? 16'h0000 : ms_q + 16'h0001;
      if (init_q != 16'h0000)
        init_q <= init_q - 16'h0001; // RULE1
      // Duration counter restarts on every state entry.
      if (state_new)
        dur_q <= 16'h0000;
      else if (tick_1ms && dur_q != 16'hFFFF)
        dur_q <= dur_q + 16'h0001;
      // Persistence restarts whenever any current sample is high.
      if (state_new || phase_current >= {8'h00, braking_current_threshold})
        pers_q <= 16'h0000;
      else if (tick_1ms && pers_q != 16'hFFFF)
        pers_q <= pers_q + 16'h0001; // RULE17
      if (state_q == S_ISD && spin_valid) begin
        isd_speed_q <= phase_speed; // RULE22
        isd_angle_q <= phase_angle; // RULE22
        isd_rev_q <= spin_reverse; // RULE22
      end
      if (state_q == S_REVCL && state_d == S_OPEN)
        rev_open_q <= 1'b1; // RULE11
      else if (state_q == S_OPEN && rev_open_q && phase_speed == 16'h0000) begin
        rev_open_q <= 1'b0; // RULE12
        isd_rev_q <= 1'b0; // RULE12
      end
      if (state_d == S_IDLE)
        rev_open_q <= 1'b0;
      if (!ctrl_q[`MSS_B_DIRGO])
        dir_seen_q <= 1'b0;
      else if (dir_req) begin
        dir_seen_q <= 1'b1;
        isd_rev_q <= ctrl_q[`MSS_B_DIRMODE]; // RULE4
      end
    end
  end

  // Registered drive outputs decoded from the next state.
  always @(posedge mclk) begin
    if (!nrst) begin
      init_request <= 1'b1;
      sleep_mode <= 1'b0;
      standby_mode <= 1'b0;
      spin_detect_start <= 1'b0;
      hs_on <= 3'h0;
      ls_on <= 3'h0;
      bridge_drive <= 1'b0;
      startup_run <= 1'b0;
      open_loop_run <= 1'b0;
      closed_loop_run <= 1'b0;
      reverse_run <= 1'b0;
      seed_valid <= 1'b0;
      seed_speed <= 16'h0000;
      seed_angle <= 16'h0000;
    end else begin
      init_request <= (state_d == S_INIT); // RULE1
      sleep_mode <= (state_d == S_IDLE) &&
        use_sleep(ctrl_q[`MSS_B_IDLE], speed_wake_pin); // RULE2
      standby_mode <= (state_d == S_IDLE) &&
        !use_sleep(ctrl_q[`MSS_B_IDLE], speed_wake_pin); // RULE2
      spin_detect_start <= (state_d == S_ISD); // RULE22
      // Coast leaves all six switches off; brake shorts one side.
      hs_on <= (state_d == S_BRAKE && !ctrl_q[`MSS_B_BRKTYPE] &&
        ctrl_q[`MSS_B_BRKSIDE]) ? 3'h7 : 3'h0; // RULE19
      ls_on <= (state_d == S_BRAKE && (ctrl_q[`MSS_B_BRKTYPE] ||
        !ctrl_q[`MSS_B_BRKSIDE])) ? 3'h7 : 3'h0; // RULE19
      bridge_drive <= (state_d == S_START || state_d == S_OPEN ||
        state_d == S_CLOSED || state_d == S_REVCL); // RULE14
      startup_run <= (state_d == S_START); // RULE20
      open_loop_run <= (state_d == S_OPEN); // RULE12
      closed_loop_run <= (state_d == S_CLOSED) ||
        (state_d == S_REVCL); // RULE21
      reverse_run <= (state_d == S_REVCL) ||
        (state_d == S_OPEN && (rev_open_q || state_q == S_REVCL)); // RULE11
      seed_valid <= (state_q == S_REJOIN && state_d == S_CLOSED); // RULE9
      if (state_q == S_REJOIN && state_d == S_CLOSED) begin
        seed_speed <= isd_speed_q; // RULE9
        seed_angle <= isd_angle_q; // RULE9
      end
    end
  end

  // AXI4-Lite slave. Address and data are taken in either order; the
  // response follows one cycle after both are present.
  always @(posedge mclk) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MSS_RESP_OKAY;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      ctrl_q <= `MSS_CTRL_RST;
      thr0_q <= `MSS_THR0_RST;
      thr1_q <= `MSS_THR1_RST;
      time_q <= `MSS_TIME_RST;
    end else begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid &&
        !s_axi_bvalid;
      s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid &&
        !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_hold_q && w_hold_q && !s_axi_bvalid) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `MSS_RESP_OKAY;
        case (awaddr_q)
          `MSS_OFF_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
          `MSS_OFF_THR0: thr0_q <= merge(thr0_q, wdata_q, wstrb_q);
          `MSS_OFF_THR1: thr1_q <= merge(thr1_q, wdata_q, wstrb_q);
          `MSS_OFF_TIME: time_q <= merge(time_q, wdata_q, wstrb_q);
          `MSS_OFF_STAT, `MSS_OFF_ISD: s_axi_bresp <= `MSS_RESP_OKAY;
          default: s_axi_bresp <= `MSS_RESP_DECERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: one read at a time, data registered with rvalid.
  always @(posedge mclk) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MSS_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `MSS_RESP_OKAY;
        case (s_axi_araddr)
          `MSS_OFF_CTRL: s_axi_rdata <= {21'h0, ctrl_q[10:0]};
          `MSS_OFF_THR0: s_axi_rdata <= thr0_q;
          `MSS_OFF_THR1: s_axi_rdata <= thr1_q;
          `MSS_OFF_TIME: s_axi_rdata <= time_q;
          `MSS_OFF_STAT: s_axi_rdata <= {16'h0000, rd_stat};
          `MSS_OFF_ISD: s_axi_rdata <= {isd_angle_q, isd_speed_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MSS_RESP_DECERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // mss_start_sequencer

// ==== bench/mss_seq_chk_sva.sv ====
// Purpose: Concurrent checks on the start sequencer ports.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Windows allow for the one-cycle judgement steps.
`timescale 1ns/1ps
module mss_seq_chk (
  input wire mclk,
  input wire nrst,
  input wire [15:0] speed_command,
  input wire params_loaded,
  input wire startup_done,
  input wire init_request,
  input wire sleep_mode,
  input wire standby_mode,
  input wire spin_detect_start,
  input wire [2:0] hs_on,
  input wire [2:0] ls_on,
  input wire startup_run,
  input wire open_loop_run,
  input wire closed_loop_run,
  input wire reverse_run,
  input wire seed_valid
);
  wire idle = sleep_mode | standby_mode;
  // Every check shares the clock and is quiet during reset.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  a_init_wait: assert property (init_request && !params_loaded |=> init_request)
    else $error("init left before parameters were loaded");
  a_idle_excl: assert property (!(sleep_mode && standby_mode))
    else $error("sleep and standby at once");
  a_idle_stay: assert property (idle && speed_command == 16'h0000 |=> idle)
    else $error("idle left with zero speed command");
  a_wake_leave: assert property (idle && speed_command != 16'h0000 |-> ##[1:4] !idle)
    else $error("idle kept with nonzero speed command");
  a_brake_low: assert property (ls_on != 3'h0 |-> hs_on == 3'h0 && ls_on == 3'h7)
    else $error("low-side brake not on all phases alone");
  a_brake_high: assert property (hs_on != 3'h0 |-> hs_on == 3'h7 && ls_on == 3'h0)
    else $error("high-side brake not on all phases alone");
  a_seed_closed: assert property (seed_valid |-> closed_loop_run && !open_loop_run)
    else $error("seed without closed loop");
  a_seed_pulse: assert property ($rose(seed_valid) |=> !seed_valid)
    else $error("seed pulse too long");
  a_start_open: assert property (startup_run && startup_done |-> ##[1:3] open_loop_run)
    else $error("no open loop after start-up method");
  a_one_mode: assert property ($onehot0({init_request, idle, spin_detect_start, startup_run, open_loop_run, closed_loop_run}))
    else $error("more than one drive mode active");
  c_seed: cover property (seed_valid);
  c_brake: cover property (ls_on == 3'h7);
  c_rev: cover property (reverse_run && closed_loop_run);
endmodule // mss_seq_chk
bind mss_start_sequencer mss_seq_chk chk (.mclk, .nrst, .speed_command,
  .params_loaded, .startup_done, .init_request, .sleep_mode, .standby_mode,
  .spin_detect_start, .hs_on, .ls_on, .startup_run, .open_loop_run,
  .closed_loop_run, .reverse_run, .seed_valid);

// ==== bench/mss_motor_model.sv ====
// Purpose: Behavioural power stage and motor facing the sequencer.
// Assumes: The bench sets speed, direction and brake current.
// Notes: Detection results are inverted except while a detection has run DET_CYC cycles.
`timescale 1ns/1ps
module mss_motor_model #(
  parameter int LOAD_CYC = 40,
  parameter int DET_CYC = 6
) (
  input wire mclk,
  input wire nrst,
  input wire spin_detect_start,
  input wire startup_run,
  input wire [2:0] ls_on,
  input wire [15:0] speed_set,
  input wire rev_set,
  input wire [15:0] cur_set,
  output wire params_loaded,
  output wire spin_valid,
  output wire [15:0] phase_emf,
  output wire [15:0] phase_speed,
  output wire [15:0] phase_angle,
  output wire spin_reverse,
  output wire [15:0] phase_current,
  output wire startup_done
);
  int load_q;
  int det_q;
  int run_q;
  // Time taken by the memory load, the detection and the start-up method.
  always @(posedge mclk) begin
    if (!nrst) begin
      load_q <= 0;
      det_q <= 0;
      run_q <= 0;
    end else begin
      load_q <= load_q + ((load_q < LOAD_CYC) ? 1 : 0);
      det_q <= spin_detect_start ? det_q + 1 : 0;
      run_q <= startup_run ? run_q + 1 : 0;
    end
  end
  // Stale detection results are inverted so a misuse cannot pass.
  assign params_loaded = load_q >= LOAD_CYC;
  assign spin_valid = det_q >= DET_CYC;
  assign phase_emf = spin_valid ? speed_set : ~speed_set;
  assign spin_reverse = spin_valid ? rev_set : ~rev_set;
  assign phase_speed = speed_set;
  assign phase_angle = 16'h1234;
  // Only a shorted low side carries braking current here.
  assign phase_current = (ls_on != 3'h0) ? cur_set : 16'h0000;
  assign startup_done = run_q >= 5;
endmodule // mss_motor_model

// ==== bench/tb.sv ====
// Purpose: Self-checking bench for the motor start sequencer.
// Assumes: One millisecond is shortened to 40 clock cycles.
// Notes: Durations are judged in windows wide enough for tick alignment.
`timescale 1ns/1ps
`include "mss_consts.vh"
module tb;
  localparam int MS = 40;
  localparam logic [6:0] STB = 7'h20, SUP = 7'h10, OL = 7'h08;
  localparam logic [6:0] CL = 7'h04, RV = 7'h02, SD = 7'h01;
  localparam logic [15:0] FAST = 16'h0080, SLOW = 16'h0030;
  int n_mismatch = 0;
  int comparisons = 0;
  logic mclk = 1'h0, nrst = 1'h0, speed_wake_pin = 1'h0, rev_set = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [15:0] speed_command = 16'h0, speed_set = 16'h0, cur_set = 16'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, params_loaded, spin_reverse, spin_valid, startup_done;
  wire init_request, sleep_mode, standby_mode, spin_detect_start;
  wire bridge_drive, startup_run, open_loop_run, closed_loop_run;
  wire reverse_run, seed_valid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] phase_emf, phase_speed, phase_angle, phase_current;
  wire [15:0] seed_speed, seed_angle;
  wire [2:0] hs_on, ls_on;
  wire [6:0] st = {sleep_mode, standby_mode, startup_run, open_loop_run,
    closed_loop_run, reverse_run, seed_valid};
  mss_start_sequencer #(.MS_US(2), .INIT_CYC(20)) uut (.mclk, .nrst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .speed_command,
    .speed_wake_pin, .params_loaded, .phase_emf, .phase_speed, .phase_angle,
    .spin_reverse, .spin_valid, .phase_current, .startup_done, .init_request,
    .sleep_mode, .standby_mode, .spin_detect_start, .hs_on, .ls_on,
    .bridge_drive, .startup_run, .open_loop_run, .closed_loop_run,
    .reverse_run, .seed_valid, .seed_speed, .seed_angle);
  mss_motor_model motor (.mclk, .nrst, .spin_detect_start, .startup_run,
    .ls_on, .speed_set, .rev_set, .cur_set, .params_loaded, .spin_valid,
    .phase_emf, .phase_speed, .phase_angle, .spin_reverse, .phase_current,
    .startup_done);
  // Free-running 20 MHz clock.
  always #25 mclk = ~mclk;
  // Compare one value and count the outcome.
  task automatic check(input logic [33:0] s, input logic [33:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t ns: saw %h expected %h", $time, s, e);
    end
  endtask
  // Print the counts and the verdict, then stop.
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Bus write; address and data are released as each is taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    check(s_axi_bresp, er);
    s_axi_bready <= 1'h0;
  endtask
  // Bus read; data and response are taken with rvalid.
  task automatic axi_rd(input logic [7:0] a, output logic [33:0] dr);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    dr = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'h0;
  endtask
  // Wait, within a bound, until all outputs in a mask are high.
  task automatic wait_mask(input logic [6:0] m, input int lim,
      output int n);
    n = 0;
    while ((st & m) !== m && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask
  // Configure, set the motor and raise the speed command.
  task automatic start(input logic [31:0] c, input logic [15:0] sp,
      input logic r, input logic [15:0] cur);
    axi_wr(`MSS_OFF_CTRL, c, `MSS_RESP_OKAY);
    @(posedge mclk);
    speed_set <= sp;
    rev_set <= r;
    cur_set <= cur;
    speed_command <= 16'h0100;
  endtask
  // Drop the command and expect the idle state again.
  task automatic stop;
    int n;
    @(posedge mclk);
    speed_command <= 16'h0000;
    wait_mask(STB, 2000, n);
    check(n < 2000, 1'h1);
  endtask
  // Init holds until loaded; then register defaults and a bad address.
  task automatic t_init;
    logic [33:0] d;
    int n;
    repeat (30) @(posedge mclk);
    #1;
    check(init_request, 1'h1);
    wait_mask(STB, 100, n);
    check({init_request, standby_mode}, 2'h1);
    axi_rd(`MSS_OFF_THR0, d);
    check(d, {`MSS_RESP_OKAY, `MSS_THR0_RST});
    axi_rd(`MSS_OFF_THR1, d);
    check(d, {`MSS_RESP_OKAY, `MSS_THR1_RST});
    axi_rd(8'h18, d);
    check(d, {`MSS_RESP_DECERR, 32'h0});
    axi_wr(8'h18, 32'h1, `MSS_RESP_DECERR);
    axi_wr(`MSS_OFF_TIME, 32'h4002_0502, `MSS_RESP_OKAY);
    axi_rd(`MSS_OFF_TIME, d);
    check(d, {`MSS_RESP_OKAY, 32'h4002_0502});
  endtask
  // Idle kind follows the mode bit and the wake pin.
  task automatic t_idle;
    int n;
    axi_wr(`MSS_OFF_CTRL, 32'h1, `MSS_RESP_OKAY);
    wait_mask(7'h40, 20, n);
    check(st[6:5], 2'h2);
    @(posedge mclk);
    speed_wake_pin <= 1'h1;
    wait_mask(STB, 20, n);
    check(st[6:5], 2'h1);
  endtask
  // Run to one drive mode, change the speed, expect a second mode.
  task automatic flow(input logic [31:0] c, input logic [15:0] sp, sp2,
      input logic r, input logic [6:0] m1, m2);
    int n;
    start(c, sp, r, 16'h0000);
    wait_mask(m1, 300, n);
    check(st & m1, m1);
    if (m1[0]) check({seed_angle, seed_speed}, {16'h1234, sp});
    @(posedge mclk);
    speed_set <= sp2;
    wait_mask(m2, 300, n);
    check(st & m2, m2);
    stop;
  endtask
  // Direction change while running, in either change mode.
  task automatic t_dir(input logic [31:0] c, input logic [6:0] m);
    int n;
    start(c, FAST, 1'h0, 16'h0000);
    wait_mask(CL, 300, n);
    axi_wr(`MSS_OFF_CTRL, c | 32'h600, `MSS_RESP_OKAY);
    wait_mask(m, 300, n);
    check(st & m, m);
    stop;
  endtask
  // Coast or brake: bridge state mid-way and the time to start-up.
  task automatic timed(input logic [31:0] c, input logic r,
      input logic [15:0] cur, input logic [5:0] hl, input int lo, hi);
    int n;
    start(c, FAST, r, cur);
    repeat (30) @(posedge mclk);
    #1;
    check({hs_on, ls_on}, hl);
    if (hl == 6'h00) check(bridge_drive, 1'h0);
    wait_mask(SUP, 400, n);
    check(n + 30 >= lo && n + 30 <= hi, 1'h1);
    stop;
  endtask
  // Hang guard.
  initial begin
    #(30000 * 50);
    n_mismatch++;
    complete_run;
  end
  // Main sequence.
  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'h1;
    t_init;
    t_idle;
    flow(32'h000, FAST, FAST, 1'h0, SUP, OL);
    flow(32'h002, 16'h0008, 16'h0008, 1'h0, SUP, OL);
    flow(32'h00A, FAST, FAST, 1'h0, SD | CL, CL);
    flow(32'h00A, SLOW, SLOW, 1'h0, OL, CL);
    flow(32'h012, FAST, 16'h0010, 1'h1, RV | CL, RV | OL);
    flow(32'h002, FAST, FAST, 1'h1, SUP, OL);
    t_dir(32'h00E, RV | CL);
    t_dir(32'h00A, SD | CL);
    timed(32'h022, 1'h1, 16'h0, 6'h00, MS, 4 * MS);
    timed(32'h140, 1'h0, FAST, 6'h38, 4 * MS, 7 * MS);
    timed(32'h040, 1'h0, FAST, 6'h07, 4 * MS, 7 * MS);
    timed(32'h0C0, 1'h0, FAST, 6'h07, 4 * MS, 7 * MS);
    timed(32'h0C0, 1'h0, 16'h0010, 6'h07, MS, 7 * MS / 2);
    complete_run;
  end
endmodule // tb
